//--- rtl/alc_cell.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module alc_cell
	import alc_pkg::*;
#(
	parameter int CELL_INDEX     = 0, // Position of the cell in its cluster.
	parameter bit MEMORY_CLUSTER = 0  // Cell sits in a memory-capable cluster.
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        in_a,
	input  wire logic        in_b,
	input  wire logic        in_c,
	input  wire logic        in_d,
	input  wire logic        in_e_lo,
	input  wire logic        in_e_hi,
	input  wire logic        in_f_lo,
	input  wire logic        in_f_hi,
	input  wire logic [2:0]  cluster_clk_en,
	input  wire logic [1:0]  cluster_clr,
	input  wire logic        sync_clear,
	input  wire logic        sync_load,
	input  wire logic        global_clear_n,
	input  wire logic        carry_in,
	input  wire logic        shared_in,
	output logic      [3:0]  out_gen,
	output logic             carry_out,
	output logic             shared_out
);

	// Elaboration check: a cluster holds two halves of cells, nothing beyond them.
	if (CELL_INDEX < 0 || CELL_INDEX >= 2 * ALC_HALF_CELLS)
	begin : g_index_check
		$error("CELL_INDEX out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file.
	logic [63:0] mask0_ff;   // Table mask of the low half.
	logic [63:0] mask1_ff;   // Table mask of the high half.
	logic [31:0] mode_ff;    // Mode register.
	logic [31:0] flop_ff;    // Per-flop controls.
	logic [31:0] prdata_ff;  // Read data.
	logic        pready_ff;  // Access-phase ready.
	logic        pslverr_ff; // Error answer.
	logic [31:0] status;     // Live cell state.
	logic [31:0] rd_word;    // Decoded read value.
	logic        hit;        // Address maps to a register.
	logic        wr_go;      // Write completes this edge.

	// Merges write data into a word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		merge = old;
		for (int b = 0; b < 4; b++)
		begin
			if (st[b])
				merge[b*8 +: 8] = wd[b*8 +: 8];
		end
	endfunction : merge

	// Address decode shared by read and write.
	always_comb
	begin
		hit     = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (paddr)
			ALC_OFF_MASK0_LO: rd_word = mask0_ff[31:0];
			ALC_OFF_MASK0_HI: rd_word = mask0_ff[63:32];
			ALC_OFF_MASK1_LO: rd_word = mask1_ff[31:0];
			ALC_OFF_MASK1_HI: rd_word = mask1_ff[63:32];
			ALC_OFF_MODE:     rd_word = mode_ff;
			ALC_OFF_FLOP:     rd_word = flop_ff;
			ALC_OFF_STATUS:   rd_word = status;
			default:          hit     = 1'b0;
		endcase
	end

	assign wr_go = psel && penable && pready_ff && pwrite && hit;

	// Answer one cycle after setup: ready is high for the first access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= psel && !penable;
			pslverr_ff <= psel && !penable && !hit;
			// Read data is captured in setup so it is stable through access.
			if (psel && !penable && !pwrite)
				prdata_ff <= rd_word;
		end
	end

	// Register writes; the status word ignores writes.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask0_ff <= {ALC_RST_WORD, ALC_RST_WORD};
			mask1_ff <= {ALC_RST_WORD, ALC_RST_WORD};
			mode_ff  <= ALC_RST_WORD;
			flop_ff  <= ALC_RST_WORD;
		end
		else if (wr_go)
		begin
			unique case (paddr)
				ALC_OFF_MASK0_LO: mask0_ff[31:0]  <= merge(mask0_ff[31:0], pwdata, pstrb);
				ALC_OFF_MASK0_HI: mask0_ff[63:32] <= merge(mask0_ff[63:32], pwdata, pstrb);
				ALC_OFF_MASK1_LO: mask1_ff[31:0]  <= merge(mask1_ff[31:0], pwdata, pstrb);
				ALC_OFF_MASK1_HI: mask1_ff[63:32] <= merge(mask1_ff[63:32], pwdata, pstrb);
				ALC_OFF_MODE:     mode_ff         <= merge(mode_ff, pwdata, pstrb);
				ALC_OFF_FLOP:     flop_ff         <= merge(flop_ff, pwdata, pstrb);
				default:          mode_ff         <= mode_ff;
			endcase
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the clears, which arrive from outside the clock.
	logic [2:0] clr_meta_ff; // First stage, read only by the second.
	logic [2:0] clr_sync_ff; // {global clear, cluster clear 1, cluster clear 0}, high active.

	// Two flops per clear; a reset leaves every clear inactive.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clr_meta_ff <= 3'h0;
			clr_sync_ff <= 3'h0;
		end
		else
		begin
			clr_meta_ff <= {!global_clear_n, cluster_clr};
			clr_sync_ff <= clr_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoded controls.
	alc_mode_t  mode;      // Operating mode.
	alc_nsub_t  nsub;      // Normal-mode layout.
	logic       ext_fhi;   // Extended mode selects on in_f_hi.
	logic       pack_alt;  // Packed input is the f input.
	logic [3:0] osel;      // General output drawn from a flop.
	logic [3:0] q;         // Flop outputs.

	assign mode     = alc_mode_t'(mode_ff[ALC_MODE_LSB +: 2]);
	assign nsub     = alc_nsub_t'(mode_ff[ALC_NSUB_LSB +: 2]);
	assign ext_fhi  = mode_ff[ALC_EXT_FHI_BIT];
	assign pack_alt = mode_ff[ALC_PACK_ALT_BIT];
	assign osel     = mode_ff[ALC_OSEL_LSB +: 4];

	////////////////////////////////////////////////////////////////////////////////
	// Table inputs, with optional flop feedback in place of c and d.
	logic c_in; // Input c as seen by the tables.
	logic d_in; // Input d as seen by the tables.

	assign c_in = mode_ff[ALC_FB_BIT] ? q[0] : in_c;
	assign d_in = mode_ff[ALC_FB_BIT] ? q[2] : in_d;

	// Adds two bits per cell; both carry-in cases are formed and then selected,
	// which keeps the chain delay to one mux per cell.
	function automatic logic [2:0] add2(input logic x0, input logic y0, input logic x1,
		input logic y1, input logic ci);
		logic c0;
		c0   = (x0 & y0) | (x0 & ci) | (y0 & ci);
		add2 = {(x1 & y1) | (x1 & c0) | (y1 & c0), x1 ^ y1 ^ c0, x0 ^ y0 ^ ci};
	endfunction : add2

	////////////////////////////////////////////////////////////////////////////////
	// Combinational functions of every mode.
	logic       f6_lo;    // Six-input on a..d, e-lo, f-hi.
	logic       f6_hi;    // Six-input on a..d, e-hi, f-lo.
	logic       h5_lo;    // Five-input on a, b, c, e-lo, f-lo.
	logic       h5_hi;    // Five-input on a, b, d, e-hi, f-hi.
	logic       f7;       // Seven-input result.
	logic       x0;       // First operand, low adder.
	logic       y0;       // Second operand, low adder.
	logic       x1;       // First operand, high adder.
	logic       y1;       // Second operand, high adder.
	logic       sh_k0;    // Shared carry of the low half.
	logic       sh_k1;    // Shared carry of the high half.
	logic       sub;      // Subtract, taken from in_e_lo.
	logic       start_ok; // Chain may start in this cell.
	logic       byp_ok;   // Chains may bypass this cell.
	logic       cin;      // Carry entering the low adder.
	logic [2:0] sum_c0;   // Adder result with carry in low.
	logic [2:0] sum_c1;   // Adder result with carry in high.
	logic [2:0] sum;      // {carry, high sum, low sum}.
	logic [1:0] comb;     // Results per half.
	logic       pack_lo;  // Packed input to flops 0 and 1.
	logic       pack_hi;  // Packed input to flops 2 and 3.
	logic       free_lo;  // Flops 0 and 1 take only packed data.
	logic       free_hi;  // Flops 2 and 3 take only packed data.

	assign h5_lo = alc_lut5(mask0_ff[31:0], {in_f_lo, in_e_lo, c_in, in_b, in_a});
	assign h5_hi = alc_lut5(mask1_ff[31:0], {in_f_hi, in_e_hi, d_in, in_b, in_a});
	assign f6_lo = alc_lut6(mask0_ff, {in_f_hi, in_e_lo, d_in, c_in, in_b, in_a});
	assign f6_hi = alc_lut6(mask1_ff, {in_f_lo, in_e_hi, d_in, c_in, in_b, in_a});

	// The seven-input template: the chosen f input selects between two six-input tables.
	assign f7 = (ext_fhi ? in_f_hi : in_f_lo)
		? alc_lut6(mask1_ff, {in_e_hi, in_e_lo, d_in, c_in, in_b, in_a})
		: alc_lut6(mask0_ff, {in_e_hi, in_e_lo, d_in, c_in, in_b, in_a});

	assign sub = (mode == ALC_ARITH) && in_e_lo;

	// Adder operands; shared mode forms sum and carry tables per half.
	always_comb
	begin
		sh_k0 = alc_lut4(mask0_ff[31:16], {in_e_lo, c_in, in_b, in_a});
		sh_k1 = alc_lut4(mask1_ff[31:16], {in_e_hi, d_in, in_b, in_a});
		if (mode == ALC_SHARED)
		begin
			x0 = alc_lut4(mask0_ff[15:0], {in_e_lo, c_in, in_b, in_a});
			y0 = shared_in;
			x1 = alc_lut4(mask1_ff[15:0], {in_e_hi, d_in, in_b, in_a});
			y1 = sh_k0;
		end
		else
		begin
			x0 = alc_lut4(mask0_ff[15:0], {in_f_lo, c_in, in_b, in_a});
			y0 = alc_lut4(mask0_ff[31:16], {in_f_lo, c_in, in_b, in_a}) ^ sub;
			x1 = alc_lut4(mask1_ff[15:0], {in_f_hi, d_in, in_b, in_a});
			y1 = alc_lut4(mask1_ff[31:16], {in_f_hi, d_in, in_b, in_a}) ^ sub;
		end
	end

	// Start and bypass are honoured only in the cells that allow them.
	always_comb
	begin
		if (mode == ALC_SHARED)
			start_ok = mode_ff[ALC_CH_START_BIT]
				&& (CELL_INDEX == 0 || CELL_INDEX == ALC_SHARE_START2);
		else
			start_ok = mode_ff[ALC_CH_START_BIT]
				&& (CELL_INDEX == 0 || CELL_INDEX == ALC_CARRY_START2);
		// Logic clusters skip the bottom half, memory-capable ones the top.
		if (MEMORY_CLUSTER)
			byp_ok = mode_ff[ALC_CH_BYP_BIT] && (CELL_INDEX >= ALC_HALF_CELLS);
		else
			byp_ok = mode_ff[ALC_CH_BYP_BIT] && (CELL_INDEX < ALC_HALF_CELLS);
	end

	// A started chain takes the subtract bit as its first carry.
	assign cin    = start_ok ? sub : carry_in;
	assign sum_c0 = add2(x0, y0, x1, y1, 1'b0);
	assign sum_c1 = add2(x0, y0, x1, y1, 1'b1);
	assign sum    = cin ? sum_c1 : sum_c0;

	// Results per half for each mode.
	always_comb
	begin
		unique case (mode)
			ALC_NORMAL:
			begin
				unique case (nsub)
					ALC_SPLIT:  comb = {h5_hi, h5_lo};
					ALC_SIX_LO: comb = {f6_lo, f6_lo};
					ALC_SIX_HI: comb = {f6_hi, f6_hi};
					ALC_SIX_RS: comb = {h5_hi, h5_lo};  // Reserved layout acts as split.
				endcase
			end
			ALC_EXTENDED: comb = {f7, f7};
			ALC_ARITH, ALC_SHARED:
			begin
				// Table outputs may leave while only the carry is used.
				if (mode_ff[ALC_ARITH_CMB_BIT])
					comb = {x1, x0};
				else
					comb = sum[1:0];
			end
		endcase
		// The last carry of a chain leaves through this cell's output.
		if (mode_ff[ALC_CY_OUT_BIT])
			comb[1] = carry_in;
	end

	// Which inputs are spare for register packing, and which flop pair they reach.
	always_comb
	begin
		pack_lo = in_e_lo;
		pack_hi = in_e_hi;
		free_lo = 1'b0;
		free_hi = 1'b0;
		if (mode == ALC_NORMAL && nsub == ALC_SIX_LO)
		begin
			pack_hi = pack_alt ? in_f_lo : in_e_hi;
			free_hi = 1'b1;
		end
		else if (mode == ALC_NORMAL && nsub == ALC_SIX_HI)
		begin
			pack_lo = pack_alt ? in_f_hi : in_e_lo;
			free_lo = 1'b1;
		end
		else if (mode == ALC_EXTENDED && !ext_fhi)
		begin
			pack_hi = in_f_hi;
			free_hi = 1'b1;
		end
		else if (mode == ALC_EXTENDED)
		begin
			pack_lo = in_f_lo;
			free_lo = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Chain outputs; a bypassing cell passes both chains straight through.
	assign carry_out  = byp_ok ? carry_in : sum[2];
	assign shared_out = byp_ok ? shared_in
		: (mode == ALC_SHARED ? sh_k1 : 1'b0);

	assign status = {24'h00_0000, shared_out, carry_out, comb, q};

	////////////////////////////////////////////////////////////////////////////////
	// Flop controls.
	alc_flop_if fbus ();

	// Per-flop enables, clears and data sources.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			logic [7:0] cfg;
			logic       pk;
			cfg = flop_ff[i*ALC_FL_BYTE +: ALC_FL_BYTE];
			pk  = (i < 2) ? pack_lo : pack_hi;
			// Enable 3 means free running; others follow a cluster clock enable.
			fbus.ce[i] = (cfg[ALC_FL_CE_LSB +: 2] == 2'h3)
				|| cluster_clk_en[cfg[ALC_FL_CE_LSB +: 2]];
			// In arithmetic mode in_e_hi is the counter enable.
			if (mode == ALC_ARITH)
				fbus.ce[i] = fbus.ce[i] && in_e_hi;
			fbus.sclr[i]  = sync_clear && cfg[ALC_FL_SCLR_BIT];
			fbus.sload[i] = sync_load && cfg[ALC_FL_SLOAD_BIT];
			fbus.ldata[i] = pk;
			// The global clear needs its enable; cluster clears pick one of two.
			fbus.aclr[i]  = (clr_sync_ff[2] && mode_ff[ALC_GCLR_EN_BIT])
				|| (cfg[ALC_FL_ACLR_LSB +: 2] == 2'h1 && clr_sync_ff[0])
				|| (cfg[ALC_FL_ACLR_LSB +: 2] == 2'h2 && clr_sync_ff[1]);
			if (cfg[ALC_FL_PACK_BIT] || ((i < 2) ? free_lo : free_hi))
				fbus.d[i] = pk;
			else
				fbus.d[i] = comb[i / 2];
		end
	end

	// The four flops of the cell.
	alc_flop_bank u_flops
	(
		.pclk    (pclk),
		.presetn (presetn),
		.fb      (fbus.bank)
	);

	assign q = fbus.q;

	////////////////////////////////////////////////////////////////////////////////
	// General outputs: each shows its half's direct result or its own flop, so
	// a direct and a registered copy can leave side by side.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (osel[i])
				out_gen[i] = q[i];
			else
				out_gen[i] = comb[i / 2];
		end
	end

endmodule : alc_cell

//--- inc/alc_pkg.sv
// Shared constants and types for the adaptive logic cell.
package alc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB port.
	localparam logic [7:0] ALC_OFF_MASK0_LO = 8'h00; // Low half-table mask, bits 31..0.
	localparam logic [7:0] ALC_OFF_MASK0_HI = 8'h04; // Low half-table mask, bits 63..32.
	localparam logic [7:0] ALC_OFF_MASK1_LO = 8'h08; // High half-table mask, bits 31..0.
	localparam logic [7:0] ALC_OFF_MASK1_HI = 8'h0C; // High half-table mask, bits 63..32.
	localparam logic [7:0] ALC_OFF_MODE     = 8'h10; // Mode and routing controls.
	localparam logic [7:0] ALC_OFF_FLOP     = 8'h14; // Per-flop controls, one byte each.
	localparam logic [7:0] ALC_OFF_STATUS   = 8'h18; // Read-only cell state.

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [31:0] ALC_RST_WORD = 32'h0000_0000; // All masks and controls.

	////////////////////////////////////////////////////////////////////////////////
	// Field positions in the mode register.
	localparam int ALC_MODE_LSB      = 0;  // Two bits: operating mode.
	localparam int ALC_NSUB_LSB      = 2;  // Two bits: normal-mode layout.
	localparam int ALC_EXT_FHI_BIT   = 4;  // Extended mode selects on in_f_hi.
	localparam int ALC_PACK_ALT_BIT  = 5;  // Packed input taken from the f input.
	localparam int ALC_ARITH_CMB_BIT = 6;  // Adder outputs replaced by table outputs.
	localparam int ALC_CH_START_BIT  = 7;  // This cell starts a chain.
	localparam int ALC_CH_BYP_BIT    = 8;  // This cell bypasses the chains.
	localparam int ALC_CY_OUT_BIT    = 9;  // Incoming carry driven onto general output.
	localparam int ALC_FB_BIT        = 10; // Flop feedback into the tables.
	localparam int ALC_GCLR_EN_BIT   = 11; // Global clear honoured.
	localparam int ALC_OSEL_LSB      = 12; // Four bits: output drawn from flop.

	// Field positions inside one flop byte.
	localparam int ALC_FL_CE_LSB     = 0;  // Two bits: enable select, 3 = always.
	localparam int ALC_FL_SCLR_BIT   = 2;  // Synchronous clear honoured.
	localparam int ALC_FL_SLOAD_BIT  = 3;  // Synchronous load honoured.
	localparam int ALC_FL_ACLR_LSB   = 4;  // Two bits: 0 none, 1 clear 0, 2 clear 1.
	localparam int ALC_FL_PACK_BIT   = 6;  // Data taken from the packed input.
	localparam int ALC_FL_BYTE       = 8;  // Width of one flop byte.

	// Status register positions.
	localparam int ALC_ST_COMB_LSB   = 4;  // Two combinational results.
	localparam int ALC_ST_CARRY_BIT  = 6;  // Carry leaving the cell.
	localparam int ALC_ST_SHARED_BIT = 7;  // Shared chain value leaving the cell.

	// Cells where chains may start, per cluster.
	localparam int ALC_CARRY_START2  = 4;  // Fifth cell.
	localparam int ALC_SHARE_START2  = 5;  // Sixth cell.
	localparam int ALC_HALF_CELLS    = 5;  // Cells in one cluster half.

	////////////////////////////////////////////////////////////////////////////////
	// Operating modes.
	typedef enum logic [1:0]
	{
		ALC_NORMAL   = 2'b00,
		ALC_EXTENDED = 2'b01,
		ALC_ARITH    = 2'b10,
		ALC_SHARED   = 2'b11
	} alc_mode_t;

	// Normal-mode table layouts.
	typedef enum logic [1:0]
	{
		ALC_SPLIT  = 2'b00,
		ALC_SIX_LO = 2'b01,
		ALC_SIX_HI = 2'b10,
		ALC_SIX_RS = 2'b11
	} alc_nsub_t;

	////////////////////////////////////////////////////////////////////////////////
	// Table lookups of six, five and four inputs.
	function automatic logic alc_lut6(input logic [63:0] m, input logic [5:0] i);
		alc_lut6 = m[i];
	endfunction : alc_lut6

	function automatic logic alc_lut5(input logic [31:0] m, input logic [4:0] i);
		alc_lut5 = m[i];
	endfunction : alc_lut5

	function automatic logic alc_lut4(input logic [15:0] m, input logic [3:0] i);
		alc_lut4 = m[i];
	endfunction : alc_lut4

endpackage : alc_pkg

//--- inc/alc_flop_if.sv
`timescale 1ns/1ps
// Control and data bundle between the cell logic and its four flops.
interface alc_flop_if;
	logic [3:0] d;     // Data per flop.
	logic [3:0] ce;    // Update enable per flop.
	logic [3:0] sclr;  // Synchronous clear per flop.
	logic [3:0] sload; // Synchronous load per flop.
	logic [3:0] ldata; // Load value per flop.
	logic [3:0] aclr;  // Clear with top priority per flop.
	logic [3:0] q;     // Flop outputs.

	modport ctrl (output d, ce, sclr, sload, ldata, aclr, input q);
	modport bank (input d, ce, sclr, sload, ldata, aclr, output q);
endinterface : alc_flop_if

//--- rtl/alc_flop_bank.sv
`timescale 1ns/1ps
// Four cell flops with a fixed control priority.
module alc_flop_bank
(
	input  wire logic pclk,
	input  wire logic presetn,
	alc_flop_if.bank  fb
);

	////////////////////////////////////////////////////////////////////////////////
	// Clear beats the enable, then synchronous clear, then load, then data.
	logic [3:0] q_ff;     // Flop state.
	logic [3:0] nxt_q;    // Next flop state.

	// Next-state selection; a disabled flop holds unless the clear is active.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (fb.aclr[i])
				nxt_q[i] = 1'b0;
			else if (!fb.ce[i])
				nxt_q[i] = q_ff[i];
			else if (fb.sclr[i])
				nxt_q[i] = 1'b0;
			else if (fb.sload[i])
				nxt_q[i] = fb.ldata[i];
			else
				nxt_q[i] = fb.d[i];
		end
	end

	// State update on every rising edge of the cell clock.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_ff <= 4'h0;
		else
			q_ff <= nxt_q;
	end

	assign fb.q = q_ff;

endmodule : alc_flop_bank

//--- test/alc_cell_sva.sv
`timescale 1ns/1ps
// Port-level checks on the cell's bus answers and general outputs.
module alc_cell_sva
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        global_clear_n,
	input wire logic [3:0]  out_gen
);
	logic [15:0] mode_ff; // Shadow of the mode word, so layout checks know it.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The shadow follows completed writes only, on the edge the cell takes them.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mode_ff <= 16'h0000;
		else if (psel && penable && pready && pwrite && paddr == 8'h10)
			mode_ff <= pwdata[15:0];
	sequence s_setup; psel && !penable; endsequence
	sequence s_clr_held; !global_clear_n [*3]; endsequence
	a_ready_after: assert property (s_setup |=> pready)
		else $error("no answer after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_pair_same: assert property (mode_ff[13:12] == 2'b00 && mode_ff[1:0] == 2'b00
		|-> out_gen[0] == out_gen[1]) else $error("low pair outputs differ");
	a_gclr_flop: assert property ((mode_ff[11] && mode_ff[12]) ##0 s_clr_held |=> !out_gen[0])
		else $error("global clear left flop 0 set");
endmodule : alc_cell_sva

bind alc_cell alc_cell_sva chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .global_clear_n(global_clear_n), .out_gen(out_gen));

//--- test/alc_chain_nbr.sv
`timescale 1ns/1ps
// Stands in for the previous cell on the carry and shared chains.
module alc_chain_nbr
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      carry_in,
	output logic      shared_in
);
	logic [7:0] lfsr_ff; // Pattern source; moving values expose a stuck chain input.
	// Chain values change just after each edge, as a real neighbour's would.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			lfsr_ff <= 8'hA5;
		else
			lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5]};
	assign carry_in  = lfsr_ff[0];
	assign shared_in = lfsr_ff[3];
endmodule : alc_chain_nbr

//--- test/alc_cell_tb_top.sv
`timescale 1ns/1ps
// Drives the cell over its bus and pins, and scores answers in order.
module alc_cell_tb_top;
	import alc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, look, gclr_n, cy, sh, pready, pslverr;
	logic [7:0]  paddr, din, ctl, v;
	logic [31:0] pwdata, prdata, seed;
	logic [63:0] m0, m1;
	logic [3:0]  out_gen;
	logic [36:0] q[$]; // Oldest note first: care bits, then the value.
	int          err_total, n_compared, i, n;
	alc_chain_nbr nbr_u (.pclk(pclk), .presetn(presetn), .carry_in(cy), .shared_in(sh));
	alc_cell dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_a(din[0]), .in_b(din[1]), .in_c(din[2]),
		.in_d(din[3]), .in_e_lo(din[4]), .in_e_hi(din[5]), .in_f_lo(din[6]), .in_f_hi(din[7]),
		.cluster_clk_en(ctl[2:0]), .cluster_clr(ctl[4:3]), .sync_clear(ctl[5]),
		.sync_load(ctl[6]), .global_clear_n(gclr_n), .carry_in(cy), .shared_in(sh),
		.out_gen(out_gen), .carry_out(), .shared_out());
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Takes the oldest note whenever a read answer or a pin check comes due.
	always @(posedge pclk)
		if ((pready === 1'b1 && !pwrite) || look)
		begin
			n_compared++;
			if (q.size() == 0 || (look ? ((out_gen ^ q[0][3:0]) & q[0][36:33]) !== 4'h0
				: {pslverr, prdata} !== q[0][32:0]))
			begin
				err_total++;
				$display("Error at %0t: got %h %h", $time, out_gen, prdata);
			end
			if (q.size() != 0)
				void'(q.pop_front());
		end
	task automatic test_done(input int bad);
		err_total += bad;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// One bus transfer; the request stands until ready is seen.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++k < 50);
		if (k == 50)
			test_done(1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back({4'hF, e});
		apb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic pin(input logic [3:0] care, input logic [3:0] e);
		q.push_back({care, 29'h0, e});
		look <= 1'b1;
		@(posedge pclk);
		look <= 1'b0;
		@(posedge pclk);
	endtask : pin
	// Expected outputs with no flop selected: 0 split, 1 six-input, 2 extended.
	function automatic logic [3:0] want(input int lay, input logic [7:0] x);
		logic [1:0] c;
		case (lay)
			0: c = {m1[{x[7], x[5], x[3], x[1:0]}], m0[{x[6], x[4], x[2:0]}]};
			1: c = {2{m0[{x[7], x[4], x[3:0]}]}};
			default: c = {1'b0, x[6] ? m1[x[5:0]] : m0[x[5:0]]};
		endcase
		want = {c[1], c[1], c[0], c[0]};
	endfunction : want
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'hE97B;
		{presetn, psel, penable, pwrite, look, gclr_n} = 6'b000001;
		{paddr, pwdata, din, ctl, err_total, n_compared} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Every word starts at zero; the word past status is refused.
		for (i = 0; i <= 28; i += 4)
			rd(8'(i), {i == 28, 32'h0});
		m0 = {$random(seed), $random(seed)};
		m1 = {$random(seed), $random(seed)};
		for (i = 0; i < 4; i++)
			apb(8'(4 * i), 1'b1, 32'({m1, m0} >> (32 * i)));
		// Split, six-input and extended layouts under random pins and controls.
		for (n = 0; n < 3; n++)
		begin
			apb(ALC_OFF_MODE, 1'b1, n == 1 ? 32'h4 : 32'(n / 2));
			repeat (8)
			begin
				v = 8'($random(seed));
				din <= v;
				ctl <= 8'($random(seed));
				pin(n == 2 ? 4'h3 : 4'hF, want(n, v));
			end
		end
		// Flop 0 holds the result while output 1 carries it live; then cleared.
		apb(ALC_OFF_FLOP, 1'b1, 32'h0000_0003);
		apb(ALC_OFF_MASK0_LO, 1'b1, 32'hFFFF_FFFF);
		apb(ALC_OFF_MODE, 1'b1, 32'h0000_1800);
		pin(4'h3, 4'h3);
		gclr_n <= 1'b0;
		repeat (4) @(posedge pclk);
		pin(4'h3, 4'h2);
		gclr_n <= 1'b1;
		repeat (4) @(posedge pclk);
		pin(4'h3, 4'h3);
		// Arithmetic from a started chain: x0 tables all ones, y tables zero, so
		// the low sum is one and the high sum zero, with or without subtract.
		apb(ALC_OFF_MASK1_LO, 1'b1, 32'h0000_0000);
		apb(ALC_OFF_MASK0_LO, 1'b1, 32'h0000_FFFF);
		apb(ALC_OFF_MODE, 1'b1, 32'h0000_0082);
		repeat (4)
		begin
			din <= 8'($random(seed));
			pin(4'hF, 4'h3);
		end
		test_done(0);
	end
endmodule : alc_cell_tb_top
